// [strap_led_params.svh]
`ifndef STRAP_LED_PARAMS_SVH
`define STRAP_LED_PARAMS_SVH

// Number of dual-purpose strap/indicator pins
`define STRAP_PIN_COUNT 5
// Reset value of the latched strap levels and address
`define STRAP_ADDR_RESET 5'h00
// Address that keeps the MAC-side interface isolated
`define STRAP_ISO_ADDR 5'h00
// Pin bit positions
`define STRAP_POS_ACTIVITY 0
`define STRAP_POS_COLLISION 1
`define STRAP_POS_LINK_OK 2
`define STRAP_POS_TX 3
`define STRAP_POS_RX 4
// Output enable patterns
`define STRAP_OE_ALL 5'h1F
`define STRAP_OE_NONE 5'h00

`endif

// [strap_led_pkg.sv]
`default_nettype none
`include "strap_led_params.svh"

package strap_led_pkg;

    // Five-pin vector, bit n belongs to pin n
    typedef logic [`STRAP_PIN_COUNT-1:0] strap_vec_t;

    // Sampling phase versus normal indicator operation
    typedef enum logic [0:0] {
        PH_SAMPLE = 1'b0,
        PH_RUN = 1'b1
    } strap_phase_t;

    // Pin level: asserted indication drives the inverse of the strap
    function automatic strap_vec_t led_level(input strap_vec_t strap, input strap_vec_t ind);
        led_level = strap ^ ind;
    endfunction : led_level

endpackage : strap_led_pkg

`default_nettype wire

// [strap_led_if.sv]
`timescale 1ns/100ps
`default_nettype none

interface strap_led_if;
    strap_led_pkg::strap_vec_t strap;
    strap_led_pkg::strap_vec_t ind;
    strap_led_pkg::strap_phase_t phase;
    strap_led_pkg::strap_vec_t pin_out;
    strap_led_pkg::strap_vec_t pin_oe;

    modport ctrl (output strap, output ind, output phase, input pin_out, input pin_oe);
    modport drv (input strap, input ind, input phase, output pin_out, output pin_oe);
endinterface : strap_led_if

`default_nettype wire

// [strap_led_driver.sv]
`timescale 1ns/100ps
`default_nettype none
`include "strap_led_params.svh"

module strap_led_driver (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rstn,
    // Strap and indication carrier
    strap_led_if.drv sl
);

    // Next pin state: inputs while sampling, indicators afterwards
    wire strap_led_pkg::strap_vec_t pin_out_next;
    wire strap_led_pkg::strap_vec_t pin_oe_next;
    assign pin_out_next = (sl.phase == strap_led_pkg::PH_RUN) ?
        strap_led_pkg::led_level(sl.strap, sl.ind) : `STRAP_ADDR_RESET;
    assign pin_oe_next = (sl.phase == strap_led_pkg::PH_RUN) ?
        `STRAP_OE_ALL : `STRAP_OE_NONE;

    strap_led_pkg::strap_vec_t pin_out_reg;
    strap_led_pkg::strap_vec_t pin_oe_reg;

    // Pin registers; reset keeps every pin an input
    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            pin_out_reg <= `STRAP_ADDR_RESET;
            pin_oe_reg <= `STRAP_OE_NONE;
        end else begin
            pin_out_reg <= pin_out_next;
            pin_oe_reg <= pin_oe_next;
        end
    end

    assign sl.pin_out = pin_out_reg;
    assign sl.pin_oe = pin_oe_reg;

endmodule : strap_led_driver

`default_nettype wire

// [strap_sample_led_status.sv]
`timescale 1ns/100ps
`default_nettype none
`include "strap_led_params.svh"

// Overview of operation
// - Five pins show activity, collision, link, tx, rx
// - Pins input in reset, latched, then outputs
// - Software reset keeps pin directions and straps, blanks indications
// - Asserted indication drives inverse of latched level
// - Latched levels form management address; no floating
// - Address zero tri-states MAC-side interface outputs
// - Interface and twisted-pair outputs off until reset done
module strap_sample_led_status (
    // Clock and power-on or hardware reset
    input wire logic i_clk_sys,
    input wire logic i_rstn,
    // Software reset, keeps pins as outputs but blanks their indications
    input wire logic i_soft_reset,
    // Link monitor indications, active high
    input wire logic i_link_activity,
    input wire logic i_collision,
    input wire logic i_link_ok,
    input wire logic i_tx_activity,
    input wire logic i_rx_activity,
    // Dual-purpose pins, split into in, out and enable
    input wire logic [4:0] i_strap_pin,
    output logic [4:0] o_strap_pin,
    output logic [4:0] o_strap_pin_oe,
    // Management address and output enables
    output logic [4:0] o_mgmt_addr,
    output logic o_mii_out_en,
    output logic o_tp_tx_en
);

    strap_led_if sl ();

    strap_led_pkg::strap_phase_t phase_reg;
    strap_led_pkg::strap_phase_t phase_next;
    strap_led_pkg::strap_vec_t strap_reg;
    strap_led_pkg::strap_vec_t strap_next;
    logic mii_en_reg;
    logic mii_en_next;
    logic tp_en_reg;
    logic tp_en_next;

    // Phase: one sampling edge after reset release, then run
    // Only a hardware reset brings the block back to sampling
    always_comb begin
        case (phase_reg)
            strap_led_pkg::PH_SAMPLE: phase_next = strap_led_pkg::PH_RUN;
            strap_led_pkg::PH_RUN: phase_next = strap_led_pkg::PH_RUN;
            default: phase_next = strap_led_pkg::PH_SAMPLE;
        endcase
    end

    // Strap capture only on the first edge after release
    // Async reset cannot load a pin value, so capture is clocked
    wire sample_now;
    assign sample_now = (phase_reg == strap_led_pkg::PH_SAMPLE);
    assign strap_next = sample_now ? i_strap_pin : strap_reg;

    // Address decode: zero keeps the MAC side isolated
    wire addr_iso;
    assign addr_iso = (strap_reg == `STRAP_ISO_ADDR);
    assign mii_en_next = (phase_reg == strap_led_pkg::PH_RUN) && !addr_iso;
    assign tp_en_next = (phase_reg == strap_led_pkg::PH_RUN);

    // Indication vector in pin order; quiet during software reset
    // Masking here keeps soft reset out of the pin driver
    wire strap_led_pkg::strap_vec_t ind_vec;
    assign ind_vec[`STRAP_POS_ACTIVITY] = i_link_activity && !i_soft_reset;
    assign ind_vec[`STRAP_POS_COLLISION] = i_collision && !i_soft_reset;
    assign ind_vec[`STRAP_POS_LINK_OK] = i_link_ok && !i_soft_reset;
    assign ind_vec[`STRAP_POS_TX] = i_tx_activity && !i_soft_reset;
    assign ind_vec[`STRAP_POS_RX] = i_rx_activity && !i_soft_reset;

    // State registers; software reset deliberately not in this list
    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            phase_reg <= strap_led_pkg::PH_SAMPLE;
            strap_reg <= `STRAP_ADDR_RESET;
            mii_en_reg <= 1'b0;
            tp_en_reg <= 1'b0;
        end else begin
            phase_reg <= phase_next;
            strap_reg <= strap_next;
            mii_en_reg <= mii_en_next;
            tp_en_reg <= tp_en_next;
        end
    end

    // Carrier to the pin driver
    assign sl.strap = strap_reg;
    assign sl.ind = ind_vec;
    assign sl.phase = phase_reg;

    strap_led_driver u_driver (
        .i_clk_sys(i_clk_sys),
        .i_rstn(i_rstn),
        .sl(sl)
    );

    // Outputs, each from a flip-flop
    // Enables are registered so release never glitches them
    assign o_strap_pin = sl.pin_out;
    assign o_strap_pin_oe = sl.pin_oe;
    assign o_mgmt_addr = strap_reg;
    assign o_mii_out_en = mii_en_reg;
    assign o_tp_tx_en = tp_en_reg;

    // Checks
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_rstn);

    a_pins_input_sample:
        assert property (phase_reg == strap_led_pkg::PH_SAMPLE |-> o_strap_pin_oe == 5'h00)
        else $error("strap pins driven during sampling");

    a_pins_output_run:
        assert property ($rose(phase_reg == strap_led_pkg::PH_RUN) |=> o_strap_pin_oe == 5'h1F)
        else $error("strap pins not outputs after sampling");

    a_soft_reset_keep:
        assert property (phase_reg == strap_led_pkg::PH_RUN && i_soft_reset
            |=> o_strap_pin_oe == 5'h1F && $stable(o_mgmt_addr))
        else $error("software reset disturbed strap pins");

    a_led_polarity:
        assert property (phase_reg == strap_led_pkg::PH_RUN
            |=> o_strap_pin == ($past(strap_reg) ^ $past(ind_vec)))
        else $error("indicator level not inverse of strap");

    a_addr_capture:
        assert property (phase_reg == strap_led_pkg::PH_SAMPLE
            |=> o_mgmt_addr == $past(i_strap_pin))
        else $error("address not taken from strap pins");

    a_addr_held_run:
        assert property (phase_reg == strap_led_pkg::PH_RUN ##1 phase_reg == strap_led_pkg::PH_RUN
            |-> $stable(o_mgmt_addr))
        else $error("address changed after capture");

    a_mii_iso_zero:
        assert property (phase_reg == strap_led_pkg::PH_RUN && o_mgmt_addr == 5'h00
            |=> !o_mii_out_en)
        else $error("interface enabled at address zero");

    a_mii_en_late:
        assert property ($rose(phase_reg == strap_led_pkg::PH_RUN) |-> !o_mii_out_en && !o_tp_tx_en
            ##1 (o_tp_tx_en && (o_mii_out_en == (o_mgmt_addr != 5'h00))))
        else $error("outputs enabled early or not at all");

    a_ind_map_active:
        assert property (phase_reg == strap_led_pkg::PH_RUN && !i_soft_reset && i_collision
            |=> o_strap_pin[1] != o_mgmt_addr[1])
        else $error("collision indication not on its pin");

    // Each other indication reaches its own pin, inverted from the strap
    a_act_pin_map:
        assert property (phase_reg == strap_led_pkg::PH_RUN && !i_soft_reset && i_link_activity
            |=> o_strap_pin[`STRAP_POS_ACTIVITY] != o_mgmt_addr[`STRAP_POS_ACTIVITY])
        else $error("activity indication not on its pin");

    a_link_pin_map:
        assert property (phase_reg == strap_led_pkg::PH_RUN && !i_soft_reset && i_link_ok
            |=> o_strap_pin[`STRAP_POS_LINK_OK] != o_mgmt_addr[`STRAP_POS_LINK_OK])
        else $error("link indication not on its pin");

    a_tx_pin_map:
        assert property (phase_reg == strap_led_pkg::PH_RUN && !i_soft_reset && i_tx_activity
            |=> o_strap_pin[`STRAP_POS_TX] != o_mgmt_addr[`STRAP_POS_TX])
        else $error("transmit indication not on its pin");

    a_rx_pin_map:
        assert property (phase_reg == strap_led_pkg::PH_RUN && !i_soft_reset && i_rx_activity
            |=> o_strap_pin[`STRAP_POS_RX] != o_mgmt_addr[`STRAP_POS_RX])
        else $error("receive indication not on its pin");

    // Steady run: pins stay outputs, transmit enable and nonzero-address interface enable stay up, idle pins show the strap
    a_pins_stay_out:
        assert property (phase_reg == strap_led_pkg::PH_RUN
            |=> o_strap_pin_oe == 5'h1F)
        else $error("strap pins left output mode in run");

    a_soft_blank_pins:
        assert property (phase_reg == strap_led_pkg::PH_RUN && i_soft_reset
            |=> o_strap_pin == o_mgmt_addr)
        else $error("indications shown during software reset");

    a_led_off_level:
        assert property (phase_reg == strap_led_pkg::PH_RUN && ind_vec == 5'h00
            |=> o_strap_pin == o_mgmt_addr)
        else $error("idle indicator not at strap level");

    a_tp_en_run:
        assert property (phase_reg == strap_led_pkg::PH_RUN
            |=> o_tp_tx_en)
        else $error("twisted-pair transmit not enabled in run");

    a_mii_en_nonzero:
        assert property (phase_reg == strap_led_pkg::PH_RUN && o_mgmt_addr != 5'h00
            |=> o_mii_out_en)
        else $error("interface isolated at nonzero address");

    // Sampling edge: pin drive quiet at zero and both interfaces still off
    a_pin_quiet_sample:
        assert property (phase_reg == strap_led_pkg::PH_SAMPLE
            |-> o_strap_pin == 5'h00)
        else $error("strap pin drive not quiet while sampling");

    a_en_off_sample:
        assert property (phase_reg == strap_led_pkg::PH_SAMPLE
            |-> !o_mii_out_en && !o_tp_tx_en)
        else $error("outputs enabled while sampling");

    c_nonzero_addr: cover property ($rose(o_mii_out_en));
    c_zero_addr: cover property ($rose(o_tp_tx_en) && !o_mii_out_en);
    c_soft_reset: cover property (phase_reg == strap_led_pkg::PH_RUN && i_soft_reset);
    c_led_lit: cover property (o_strap_pin_oe == 5'h1F && o_strap_pin != o_mgmt_addr);
    c_all_lit: cover property (o_strap_pin_oe == 5'h1F && o_strap_pin == ~o_mgmt_addr);

endmodule : strap_sample_led_status

`default_nettype wire

// [strap_board_model.sv]
`timescale 1ns/100ps
`default_nettype none

// Board side of the five pins: a pull resistor on each, no LED modelled
module strap_board_model (
    // Pull level strapped on each pin
    input wire logic [4:0] i_pull,
    // Device drive and enable
    input wire logic [4:0] i_drv,
    input wire logic [4:0] i_oe,
    // Resolved pin level
    output logic [4:0] o_pin
);
    // A released pin settles to its pull, never floats
    assign o_pin = (i_oe & i_drv) | (~i_oe & i_pull);
endmodule : strap_board_model

`default_nettype wire

// [test_strap_sample_led_status.sv]
`timescale 1ns/100ps
`default_nettype none

module test_strap_sample_led_status;
    logic i_clk_sys = 1'b0;
    logic i_rstn = 1'b0;
    logic i_soft_reset = 1'b0;
    logic [4:0] ind = 5'h00;
    logic [4:0] pull = 5'h00;
    logic [4:0] pin_w;
    logic [4:0] o_strap_pin;
    logic [4:0] o_strap_pin_oe;
    logic [4:0] o_mgmt_addr;
    logic o_mii_out_en;
    logic o_tp_tx_en;
    int fail_count = 0;
    int samples_checked = 0;

    strap_sample_led_status uut (
        .i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .i_soft_reset(i_soft_reset),
        .i_link_activity(ind[0]), .i_collision(ind[1]), .i_link_ok(ind[2]),
        .i_tx_activity(ind[3]), .i_rx_activity(ind[4]), .i_strap_pin(pin_w),
        .o_strap_pin(o_strap_pin), .o_strap_pin_oe(o_strap_pin_oe),
        .o_mgmt_addr(o_mgmt_addr), .o_mii_out_en(o_mii_out_en), .o_tp_tx_en(o_tp_tx_en)
    );

    strap_board_model board (.i_pull(pull), .i_drv(o_strap_pin), .i_oe(o_strap_pin_oe),
        .o_pin(pin_w));

    // 25 MHz system clock
    initial begin
        forever #20 i_clk_sys = ~i_clk_sys;
    end

    task automatic final_report;
        if (fail_count == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : final_report

    task automatic check(input string name, input logic [4:0] seen, input logic [4:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // Inputs move a fixed 2 ns after the edge
    task automatic tick;
        @(posedge i_clk_sys);
        #2;
    endtask : tick

    // Hardware reset with a strap pattern, then the sample and run edges
    task automatic test_strap(input logic [4:0] p);
        i_rstn = 1'b0;
        pull = p;
        repeat (20) tick;
        check("oe_in_reset", o_strap_pin_oe, 5'h00);
        check("tp_in_reset", {4'h0, o_tp_tx_en}, 5'h00);
        check("mii_in_reset", {4'h0, o_mii_out_en}, 5'h00);
        i_rstn = 1'b1;
        tick;
        check("addr", o_mgmt_addr, p);
        check("oe_sample", o_strap_pin_oe, 5'h00);
        check("en_sample", {3'h0, o_tp_tx_en, o_mii_out_en}, 5'h00);
        tick;
        check("oe_run", o_strap_pin_oe, 5'h1F);
        check("tp_run", {4'h0, o_tp_tx_en}, 5'h01);
        check("mii_run", {4'h0, o_mii_out_en}, {4'h0, p != 5'h00});
        check("pin_idle", o_strap_pin, p);
    endtask : test_strap

    // Each indication alone, then all together, back to back
    task automatic test_ind(input logic [4:0] p);
        for (int i = 0; i < 5; i++) begin
            ind = 5'h01 << i;
            tick;
            check("pin_one", o_strap_pin, p ^ (5'h01 << i));
        end
        ind = 5'h1F;
        tick;
        check("pin_all", o_strap_pin, p ^ 5'h1F);
        check("addr_held", o_mgmt_addr, p);
        ind = 5'h00;
        tick;
        check("pin_off", o_strap_pin, p);
    endtask : test_ind

    // Software reset blanks indications but keeps pins as outputs
    task automatic test_soft(input logic [4:0] p);
        ind = 5'h1F;
        i_soft_reset = 1'b1;
        tick;
        check("soft_pin", o_strap_pin, p);
        check("soft_oe", o_strap_pin_oe, 5'h1F);
        check("soft_addr", o_mgmt_addr, p);
        i_soft_reset = 1'b0;
        tick;
        check("soft_done", o_strap_pin, p ^ 5'h1F);
        ind = 5'h00;
        tick;
    endtask : test_soft

    // Guard against a hung run
    initial begin
        #200000;
        fail_count++;
        final_report;
    end

    initial begin
        test_strap(5'h01);
        test_ind(5'h01);
        test_soft(5'h01);
        test_strap(5'h1E);
        test_ind(5'h1E);
        test_strap(5'h15);
        test_soft(5'h15);
        test_strap(5'h00);
        test_ind(5'h00);
        final_report;
    end
endmodule : test_strap_sample_led_status

`default_nettype wire
